// *** logic/bps_bay.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// One bay: request, interlock and rail sequencing
// ------------------------------------------------------------
module bps_bay (
    input wire logic clock,
    input wire logic rstn,
    input wire logic req_wr,
    input wire logic req_wdata,
    input wire logic ilk_wr,
    input wire logic ilk_wdata,
    input wire logic present_a,
    input wire logic present_b,
    input wire logic op_good,
    output logic req_reg,
    output logic ilk_reg,
    output logic id_en_reg
);
    logic present;
    logic id_en_next;
    assign present = present_a | present_b;
    // Enable only from software request, qualified every clock
    assign id_en_next = req_reg & present & ilk_reg & op_good;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            req_reg <= bps_pkg::REQ_RST;
            ilk_reg <= bps_pkg::ILK_RST;
            id_en_reg <= bps_pkg::RAIL_RST;
        end else begin
            // Request drops by hardware on removal, no driver action needed
            if (!present)
                req_reg <= 1'b0;
            else if (req_wr)
                req_reg <= req_wdata;
            if (ilk_wr)
                ilk_reg <= ilk_wdata;
            id_en_reg <= id_en_next;
        end
    end
endmodule // bps_bay
`default_nettype wire

// *** logic/bps_pkg.sv ***
package bps_pkg;
    // ------------------------------------------------------------
    // Register map (word aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_REQ = 8'h00;
    localparam logic [7:0] ADDR_ILK = 8'h04;
    localparam logic [7:0] ADDR_STAT = 8'h08;
    localparam logic [7:0] ADDR_PRES = 8'h0c;
    localparam logic [7:0] ADDR_CFG = 8'h10;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CFG_OPREQ_POS = 0;
    localparam logic REQ_RST = 1'b0;
    localparam logic ILK_RST = 1'b0;
    localparam logic OPREQ_RST = 1'b0;
    localparam logic ACK_RST = 1'b0;
    localparam logic RAIL_RST = 1'b0;
    localparam logic [31:0] DAT_IDLE = 32'h0000_0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// *** logic/bps_top.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Each bay has its own identification rail switch, independent of others.
// - With no device present, hardware keeps the bay's rail off.
// - With neither presence pin active, a software request cannot enable the rail.
// - Presence alone never enables the rail; software must request it.
// - Rail turns off as soon as the interlock disengages.
// - Operating rails must be on before the identification rail enables.
// - Operating rails may drop once the identification rail is off.
module bps_top #(
    parameter int NBAYS = 2
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NBAYS-1:0] present_a,
    input wire logic [NBAYS-1:0] present_b,
    input wire logic [NBAYS-1:0] op_good,
    output logic [NBAYS-1:0] id_rail_en,
    output logic [NBAYS-1:0] operating_power_rails_en
);
    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (NBAYS < 1 || NBAYS > 32) begin : g_bad
        $error("NBAYS must be 1 to 32");
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic req_sel, wr_go, rd_go;
    logic hit_req, hit_ilk, hit_stat, hit_pres, hit_cfg;
    logic wr_req, wr_ilk, wr_cfg;
    logic [NBAYS-1:0] req_q, ilk_q, id_q;
    logic [NBAYS-1:0] oprq_reg;
    logic [NBAYS-1:0] oprq_next;
    logic [NBAYS-1:0] pres_vec;
    logic [31:0] rdata;
    // Single-word registers: only lane 0 is needed when NBAYS <= 8
    assign req_sel = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_go = req_sel & wb_we_i & wb_sel_i[0];
    assign rd_go = req_sel & ~wb_we_i;
    assign hit_req = (wb_adr_i == bps_pkg::ADDR_REQ);
    assign hit_ilk = (wb_adr_i == bps_pkg::ADDR_ILK);
    assign hit_stat = (wb_adr_i == bps_pkg::ADDR_STAT);
    assign hit_pres = (wb_adr_i == bps_pkg::ADDR_PRES);
    assign hit_cfg = (wb_adr_i == bps_pkg::ADDR_CFG);
    assign wr_req = wr_go & hit_req;
    assign wr_ilk = wr_go & hit_ilk;
    assign wr_cfg = wr_go & hit_cfg;
    assign pres_vec = present_a | present_b;
    assign rdata =
        hit_req ? 32'(req_q) :
        hit_ilk ? 32'(ilk_q) :
        hit_stat ? 32'(id_q) :
        hit_pres ? 32'(pres_vec) :
        hit_cfg ? 32'(oprq_reg) :
        bps_pkg::UNMAPPED_DATA;

    // ------------------------------------------------------------
    // Per-bay switch control
    // ------------------------------------------------------------
    for (genvar i = 0; i < NBAYS; i++) begin : g_bay
        bps_bay u_bay (
            .clock(clock),
            .rstn(rstn),
            .req_wr(wr_req),
            .req_wdata(wb_dat_i[i]),
            .ilk_wr(wr_ilk),
            .ilk_wdata(wb_dat_i[i]),
            .present_a(present_a[i]),
            .present_b(present_b[i]),
            .op_good(op_good[i] & oprq_reg[i]),
            .req_reg(req_q[i]),
            .ilk_reg(ilk_q[i]),
            .id_en_reg(id_q[i])
        );
    end

    // Operating rails stay up while the identification rail is on, so software cannot pull
    // them out from under a live device, except with a CFG write in the clock before id_q rises
    assign oprq_next = wr_cfg ? (wb_dat_i[NBAYS-1:0] | id_q) : (oprq_reg | id_q);

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rstn) begin
            wb_ack_o <= bps_pkg::ACK_RST;
            wb_dat_o <= bps_pkg::DAT_IDLE;
            oprq_reg <= {NBAYS{bps_pkg::OPREQ_RST}};
            id_rail_en <= {NBAYS{bps_pkg::RAIL_RST}};
            operating_power_rails_en <= {NBAYS{bps_pkg::OPREQ_RST}};
        end else begin
            wb_ack_o <= req_sel;
            wb_dat_o <= rd_go ? rdata : bps_pkg::DAT_IDLE;
            oprq_reg <= oprq_next;
            id_rail_en <= id_q;
            operating_power_rails_en <= oprq_reg;
        end
    end
endmodule // bps_top
`default_nettype wire

// *** verification/bps_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
module bps_chk #(parameter int NBAYS = 2) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [31:0] wb_dat_o,
    input wire logic [NBAYS-1:0] present_a,
    input wire logic [NBAYS-1:0] present_b,
    input wire logic [NBAYS-1:0] op_good,
    input wire logic [NBAYS-1:0] id_rail_en,
    input wire logic [NBAYS-1:0] operating_power_rails_en
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    AST_ACK: assert property (s_req |=> wb_ack_o) else $error("no ack");
    AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    AST_ACK_IDLE: assert property (!wb_stb_i |=> !wb_ack_o) else $error("stray ack");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data");
    AST_EMPTY: assert property ((id_rail_en & ~$past(present_a | present_b, 2)) == '0) else $error("empty");
    AST_OPGOOD: assert property ((id_rail_en & ~$past(op_good, 2)) == '0) else $error("op good");
    AST_OPEN: assert property ((id_rail_en & ~operating_power_rails_en) == '0) else $error("op rails");
    AST_OPDROP: assert property (($past(operating_power_rails_en) & ~operating_power_rails_en & $past(id_rail_en)) == '0) else $error("drop");
endmodule // bps_chk
bind bps_top bps_chk #(.NBAYS(NBAYS)) bps_chk_i (.clock, .rstn, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_dat_o,
    .present_a, .present_b, .op_good, .id_rail_en, .operating_power_rails_en);
`default_nettype wire

// *** verification/bps_dev_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// Removable bay device
// ------------------------------------------------------------
// Supply good lags the request a clock, as a real rail needs time to come up
module bps_dev_model (
    input wire logic clock,
    input wire logic [1:0] seat_a,
    input wire logic [1:0] seat_b,
    input wire logic [1:0] rails_en,
    input wire logic [1:0] id_rail,
    output logic [1:0] present_a,
    output logic [1:0] present_b,
    output logic [1:0] op_good,
    output logic [1:0] bus_seen
);
    assign present_a = seat_a;
    assign present_b = seat_b;
    always_ff @(posedge clock) op_good <= rails_en & (seat_a | seat_b);
    // Device joins its bus only with the identification rail up and a presence pin active
    always_ff @(posedge clock) bus_seen <= id_rail & (seat_a | seat_b);
endmodule // bps_dev_model
`default_nettype wire

// *** verification/bps_top_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("BAD %0t mismatch", $time); end end
module bps_top_bench;
    logic clock = 1'b0, rstn = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, q;
    logic [1:0] sa = 2'h0, sb = 2'h0;
    wire logic [1:0] pa, pb, og, rail, ope, bus;
    wire logic [31:0] rd;
    wire logic ack;
    int failures = 0, checks_done = 0;
    initial forever #5 clock = ~clock;
    bps_dev_model bps_dev_model_i (.clock, .seat_a(sa), .seat_b(sb), .rails_en(ope), .id_rail(rail),
        .present_a(pa), .present_b(pb), .op_good(og), .bus_seen(bus));
    bps_top #(.NBAYS(2)) bps_top_i (.clock, .rstn, .wb_cyc_i(stb), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack), .present_a(pa), .present_b(pb),
        .op_good(og), .id_rail_en(rail), .operating_power_rails_en(ope));
    task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clock); while (ack !== 1'b1);
        q = rd;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        `CHK(q, e)
    endtask
    task settle; repeat (4) @(posedge clock); endtask
    task t_on;
        rchk(bps_pkg::ADDR_REQ, 32'h0);
        rchk(8'h20, bps_pkg::UNMAPPED_DATA);
        sa <= 2'h1;
        wb(bps_pkg::ADDR_CFG, 1'b1, 32'h3);
        wb(bps_pkg::ADDR_ILK, 1'b1, 32'h3);
        settle;
        `CHK(rail, 2'h0)
        wb(bps_pkg::ADDR_REQ, 1'b1, 32'h3);
        settle;
        `CHK(rail, 2'h1)
        `CHK(bus, 2'h1)
        rchk(bps_pkg::ADDR_STAT, 32'h1);
        rchk(bps_pkg::ADDR_PRES, 32'h1);
        rchk(bps_pkg::ADDR_CFG, 32'h3);
        wb(bps_pkg::ADDR_ILK, 1'b1, 32'h2);
        settle;
        `CHK(rail, 2'h0)
        `CHK(bus, 2'h0)
        $display("t_on end");
    endtask
    task t_pull;
        wb(bps_pkg::ADDR_ILK, 1'b1, 32'h3);
        sa <= 2'h0;
        settle;
        `CHK(rail, 2'h0)
        sb <= 2'h1;
        settle;
        `CHK(rail, 2'h0)
        rchk(bps_pkg::ADDR_REQ, 32'h0);
        $display("t_pull end");
    endtask
    task t_off;
        wb(bps_pkg::ADDR_CFG, 1'b1, 32'h0);
        settle;
        sa <= 2'h2;
        wb(bps_pkg::ADDR_REQ, 1'b1, 32'h3);
        settle;
        `CHK(rail, 2'h0)
        wb(bps_pkg::ADDR_CFG, 1'b1, 32'h3);
        settle;
        `CHK(rail, 2'h3)
        `CHK(bus, 2'h3)
        wb(bps_pkg::ADDR_CFG, 1'b1, 32'h0);
        settle;
        `CHK(ope, 2'h3)
        wb(bps_pkg::ADDR_REQ, 1'b1, 32'h1);
        settle;
        `CHK(rail, 2'h1)
        wb(bps_pkg::ADDR_REQ, 1'b1, 32'h0);
        settle;
        `CHK(rail, 2'h0)
        wb(bps_pkg::ADDR_CFG, 1'b1, 32'h0);
        settle;
        `CHK(ope, 2'h0)
        $display("t_off end");
    endtask
    task report_and_stop;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        t_on;
        t_pull;
        t_off;
        report_and_stop;
    end
    initial begin
        repeat (3000) @(posedge clock);
        failures++;
        report_and_stop;
    end
endmodule // bps_top_bench
`default_nettype wire
